// [irc_ctrl.sv]
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module irc_ctrl
  import irc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic RESET_IN_N,
  input wire logic STANDBY_IN_N,
  input wire logic SUPPLY_LOST,
  input wire logic [2:0] PORT2_LOW,
  input wire logic EXT_MASKABLE_REQ_N,
  input wire logic NMI_REQ_N,
  input wire logic CAPTURE_FLAG,
  input wire logic CAPTURE_IE,
  input wire logic COMPARE_FLAG,
  input wire logic COMPARE_IE,
  input wire logic OVERFLOW_FLAG,
  input wire logic OVERFLOW_IE,
  input wire logic RX_FULL_FLAG,
  input wire logic RX_ERROR_FLAG,
  input wire logic RX_IE,
  input wire logic TX_EMPTY_FLAG,
  input wire logic TX_IE,
  input wire logic COND_CODE_MASK,
  input wire logic INSTR_BOUNDARY,
  input wire logic SOFT_INTERRUPT_INSTR,
  input wire logic UNDEFINED_OPCODE,
  input wire logic FETCH_ADDR_ERROR,
  input wire logic SLEEP_INSTRUCTION,
  input wire logic STACK_DONE,
  input wire logic RAM_RANGE_ACCESS,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RD_DATA,
  output logic E_TICK,
  output logic CPU_RESET,
  output logic ADDR_HIZ,
  output logic [2:0] BOOT_MODE,
  output logic STACK_REQ,
  output logic VECTOR_FETCH,
  output logic [15:0] VECTOR_ADDR,
  output logic MASK_SET,
  output logic CPU_HALT,
  output logic WAKE_CONTINUE,
  output logic RAM_EXTERNAL
);

  // ==========================================================
  // State declarations
  logic [1:0] div_reg, div_next;
  logic e_tick;
  logic ext_maskable_req_reg, ext_maskable_req_next;
  logic nmi_s_reg, nmi_s_next;
  logic rst_s_reg, rst_s_next;
  logic standby_in_n_s_reg, standby_in_n_s_next;
  logic [PER_NUM-1:0] per_reg, per_next;
  logic [PER_NUM-1:0] per_raw;
  logic nmi_pend_reg, nmi_pend_next;
  logic swi_pend_reg, swi_pend_next;
  logic trap_pend_reg, trap_pend_next;
  irc_state_t state_reg, state_next;
  logic [1:0] rcnt_reg, rcnt_next;
  logic [15:0] vec_reg, vec_next;
  logic stack_reg, stack_next;
  logic fetch_reg, fetch_next;
  logic mask_reg, mask_next;
  logic wake_reg, wake_next;
  logic reset_out_reg, reset_out_next;
  logic halt_reg, halt_next;
  logic hiz_reg, hiz_next;
  logic [2:0] boot_reg, boot_next;
  logic ram_on_reg, ram_on_next;
  logic standby_in_n_valid_reg, standby_in_n_valid_next;
  logic [7:0] rd_reg, rd_next;
  logic etick_reg;
  logic ramx_reg;
  logic any_req;
  logic pick_ok;
  logic [15:0] pick_vec;
  logic take;

  // ==========================================================
  // Peripheral request gating, one per source
  assign per_raw[PER_CAP] = CAPTURE_FLAG & CAPTURE_IE;
  assign per_raw[PER_CMP] = COMPARE_FLAG & COMPARE_IE;
  assign per_raw[PER_OVF] = OVERFLOW_FLAG & OVERFLOW_IE;
  // Serial sources share one lowest request
  assign per_raw[PER_SCI] = ((RX_FULL_FLAG | RX_ERROR_FLAG) & RX_IE)
                          | (TX_EMPTY_FLAG & TX_IE);

  // System clock enable
  assign e_tick = (div_reg == DIV_LAST);

  // ==========================================================
  // Priority pick over pending sources
  always_comb begin
    pick_ok = 1'b1;
    pick_vec = VEC_TRAP;
    if (trap_pend_reg) begin
      pick_vec = VEC_TRAP;
    end else if (nmi_pend_reg) begin
      pick_vec = VEC_NMI;
    end else if (swi_pend_reg) begin
      pick_vec = VEC_SWI;
    end else if (COND_CODE_MASK) begin
      pick_ok = 1'b0;
    end else if (ext_maskable_req_reg) begin
      pick_vec = VEC_EXT;
    end else if (per_reg[PER_CAP]) begin
      pick_vec = VEC_CAPTURE;
    end else if (per_reg[PER_CMP]) begin
      pick_vec = VEC_COMPARE;
    end else if (per_reg[PER_OVF]) begin
      pick_vec = VEC_OVERFLOW;
    end else if (per_reg[PER_SCI]) begin
      pick_vec = VEC_SERIAL;
    end else begin
      pick_ok = 1'b0;
    end
  end

  // Any request, masked or not, for leaving sleep
  assign any_req = trap_pend_reg | nmi_pend_reg | swi_pend_reg
                 | ext_maskable_req_reg | (|per_reg);

  // ==========================================================
  // Input sampling and pending flags
  always_comb begin
    div_next = e_tick ? 2'h0 : div_reg + 2'h1;
    ext_maskable_req_next = ext_maskable_req_reg;
    nmi_s_next = nmi_s_reg;
    rst_s_next = rst_s_reg;
    standby_in_n_s_next = standby_in_n_s_reg;
    per_next = per_reg;
    nmi_pend_next = nmi_pend_reg;
    swi_pend_next = swi_pend_reg;
    trap_pend_next = trap_pend_reg;
    // Trap, NMI and software interrupt flags taken into service are cleared first
    if (take && (pick_vec == VEC_NMI)) begin
      nmi_pend_next = 1'b0;
    end
    if (take && (pick_vec == VEC_SWI)) begin
      swi_pend_next = 1'b0;
    end
    if (take && (pick_vec == VEC_TRAP)) begin
      trap_pend_next = 1'b0;
    end
    if (e_tick) begin
      ext_maskable_req_next = ~EXT_MASKABLE_REQ_N;
      nmi_s_next = NMI_REQ_N;
      rst_s_next = RESET_IN_N;
      standby_in_n_s_next = STANDBY_IN_N;
      per_next = per_raw;
      // New events win over a clear in the same cycle
      if (nmi_s_reg && !NMI_REQ_N) begin
        nmi_pend_next = 1'b1;
      end
    end
    if (SOFT_INTERRUPT_INSTR) begin
      swi_pend_next = 1'b1;
    end
    if (UNDEFINED_OPCODE || FETCH_ADDR_ERROR) begin
      trap_pend_next = 1'b1;
    end
    // Reset drops the trap, NMI and software interrupt pending flags
    if (state_reg == ST_RESET) begin
      nmi_pend_next = 1'b0;
      swi_pend_next = 1'b0;
      trap_pend_next = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      div_reg <= 2'h0;
      ext_maskable_req_reg <= 1'b0;
      nmi_s_reg <= 1'b1;
      rst_s_reg <= 1'b0;
      standby_in_n_s_reg <= 1'b1;
      per_reg <= '0;
      nmi_pend_reg <= 1'b0;
      swi_pend_reg <= 1'b0;
      trap_pend_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      ext_maskable_req_reg <= ext_maskable_req_next;
      nmi_s_reg <= nmi_s_next;
      rst_s_reg <= rst_s_next;
      standby_in_n_s_reg <= standby_in_n_s_next;
      per_reg <= per_next;
      nmi_pend_reg <= nmi_pend_next;
      swi_pend_reg <= swi_pend_next;
      trap_pend_reg <= trap_pend_next;
    end
  end

  // ==========================================================
  // Sequencer: reset, acceptance, stacking, vector, sleep
  always_comb begin
    state_next = state_reg;
    rcnt_next = rcnt_reg;
    vec_next = vec_reg;
    stack_next = 1'b0;
    fetch_next = 1'b0;
    mask_next = 1'b0;
    wake_next = 1'b0;
    hiz_next = hiz_reg;
    boot_next = boot_reg;
    take = 1'b0;
    case (state_reg)
      ST_RUN: begin
        if (INSTR_BOUNDARY && pick_ok) begin
          take = 1'b1;
          vec_next = pick_vec;
          stack_next = 1'b1;
          state_next = ST_STACK;
        end else if (SLEEP_INSTRUCTION) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (any_req && pick_ok) begin
          take = 1'b1;
          vec_next = pick_vec;
          stack_next = 1'b1;
          state_next = ST_STACK;
        end else if (any_req) begin
          wake_next = 1'b1;
          state_next = ST_RUN;
        end
      end
      ST_STACK: begin
        if (STACK_DONE) begin
          fetch_next = 1'b1;
          mask_next = 1'b1;
          state_next = ST_VECTOR;
        end
      end
      ST_VECTOR: begin
        state_next = ST_RUN;
      end
      ST_RESET: begin
        if (e_tick && rst_s_reg && standby_in_n_s_reg) begin
          boot_next = PORT2_LOW;
          vec_next = VEC_RESET;
          fetch_next = 1'b1;
          mask_next = 1'b1;
          hiz_next = 1'b0;
          rcnt_next = 2'h0;
          state_next = ST_VECTOR;
        end else if (e_tick && (rcnt_reg != RESET_HIZ_CYCLES)) begin
          rcnt_next = rcnt_reg + 2'h1;
          hiz_next = (rcnt_reg + 2'h1) == RESET_HIZ_CYCLES;
        end
      end
      default: begin
        state_next = ST_RESET;
      end
    endcase
    // Reset pin or standby pin low overrides any state
    if (e_tick && (!rst_s_reg || !standby_in_n_s_reg) && state_reg != ST_RESET) begin
      state_next = ST_RESET;
      rcnt_next = 2'h1;
      hiz_next = 1'b0;
      stack_next = 1'b0;
      fetch_next = 1'b0;
      mask_next = 1'b0;
      wake_next = 1'b0;
    end
    // Status outputs follow the state being entered
    reset_out_next = (state_next == ST_RESET);
    halt_next = (state_next == ST_SLEEP);
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= ST_RESET;
      rcnt_reg <= 2'h0;
      vec_reg <= VEC_RESET;
      stack_reg <= 1'b0;
      fetch_reg <= 1'b0;
      mask_reg <= 1'b0;
      wake_reg <= 1'b0;
      hiz_reg <= 1'b0;
      boot_reg <= 3'h0;
      reset_out_reg <= 1'b1;
      halt_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rcnt_reg <= rcnt_next;
      vec_reg <= vec_next;
      stack_reg <= stack_next;
      fetch_reg <= fetch_next;
      mask_reg <= mask_next;
      wake_reg <= wake_next;
      hiz_reg <= hiz_next;
      boot_reg <= boot_next;
      reset_out_reg <= reset_out_next;
      halt_reg <= halt_next;
    end
  end

  // ==========================================================
  // RAM control register and read port
  always_comb begin
    ram_on_next = ram_on_reg;
    standby_in_n_valid_next = standby_in_n_valid_reg;
    rd_next = 8'h00;
    if (WR_STB && ADDR == RAM_CTRL_ADDR) begin
      ram_on_next = WR_DATA[RAM_ON_POS];
      standby_in_n_valid_next = WR_DATA[STANDBY_IN_N_VALID_POS];
    end
    // Supply loss beats a software write
    if (SUPPLY_LOST) begin
      standby_in_n_valid_next = 1'b0;
    end
    // Enable is forced on as reset releases
    if (state_reg == ST_RESET && state_next == ST_VECTOR) begin
      ram_on_next = 1'b1;
    end
    if (RD_STB && ADDR == RAM_CTRL_ADDR) begin
      rd_next[STANDBY_IN_N_VALID_POS] = standby_in_n_valid_reg;
      rd_next[RAM_ON_POS] = ram_on_reg;
    end else if (RD_STB && ADDR == IRQ_STAT_ADDR) begin
      rd_next = {state_reg, trap_pend_reg, nmi_pend_reg,
                 swi_pend_reg, ext_maskable_req_reg, |per_reg};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ram_on_reg <= RAM_ON_RST;
      standby_in_n_valid_reg <= STANDBY_IN_N_VALID_RST;
      rd_reg <= 8'h00;
      etick_reg <= 1'b0;
      ramx_reg <= 1'b0;
    end else begin
      ram_on_reg <= ram_on_next;
      standby_in_n_valid_reg <= standby_in_n_valid_next;
      rd_reg <= rd_next;
      etick_reg <= e_tick;
      ramx_reg <= RAM_RANGE_ACCESS & ~ram_on_next;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign RD_DATA = rd_reg;
  assign E_TICK = etick_reg;
  assign CPU_RESET = reset_out_reg;
  assign ADDR_HIZ = hiz_reg;
  assign BOOT_MODE = boot_reg;
  assign STACK_REQ = stack_reg;
  assign VECTOR_FETCH = fetch_reg;
  assign VECTOR_ADDR = vec_reg;
  assign MASK_SET = mask_reg;
  assign CPU_HALT = halt_reg;
  assign WAKE_CONTINUE = wake_reg;
  assign RAM_EXTERNAL = ramx_reg;

endmodule
`default_nettype wire

// [irc_pkg.sv]
package irc_pkg;
  // ==========================================================
  // System clock divider
  localparam int SYS_DIV = 4;
  localparam logic [1:0] DIV_LAST = 2'(SYS_DIV - 1);
  // ==========================================================
  // Reset hold before address lines float, in system cycles
  localparam logic [1:0] RESET_HIZ_CYCLES = 2'h3;
  // ==========================================================
  // Register map
  localparam logic [7:0] RAM_CTRL_ADDR = 8'h14;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h15;
  localparam int STANDBY_IN_N_VALID_POS = 7;
  localparam int RAM_ON_POS = 6;
  localparam logic STANDBY_IN_N_VALID_RST = 1'h0;
  localparam logic RAM_ON_RST = 1'h1;
  // ==========================================================
  // Vector addresses (high byte; low byte is the next address)
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFEE;
  localparam logic [15:0] VEC_NMI = 16'hFFFC;
  localparam logic [15:0] VEC_SWI = 16'hFFFA;
  localparam logic [15:0] VEC_EXT = 16'hFFF8;
  localparam logic [15:0] VEC_CAPTURE = 16'hFFF6;
  localparam logic [15:0] VEC_COMPARE = 16'hFFF4;
  localparam logic [15:0] VEC_OVERFLOW = 16'hFFF2;
  localparam logic [15:0] VEC_SERIAL = 16'hFFF0;
  // ==========================================================
  // Peripheral request index
  localparam int PER_CAP = 0;
  localparam int PER_CMP = 1;
  localparam int PER_OVF = 2;
  localparam int PER_SCI = 3;
  localparam int PER_NUM = 4;
  // ==========================================================
  // Controller states
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_STACK = 3'h1,
    ST_VECTOR = 3'h2,
    ST_RESET = 3'h3,
    ST_SLEEP = 3'h4
  } irc_state_t;
endpackage

// [irc_cpu_model.sv]
`timescale 1ns/1ns
`default_nettype none
module irc_cpu_model (
  input wire logic CLK,
  input wire logic RST,
  input wire logic STACK_REQ,
  input wire logic [3:0] DELAY,
  output logic STACK_DONE
);
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  // ==========
  // Register push lasts DELAY plus one cycles, then done pulses once
  always_comb begin
    cnt_next = cnt_reg;
    if (STACK_REQ) begin
      cnt_next = {1'b0, DELAY} + 5'h1;
    end else if (cnt_reg != 5'h0) begin
      cnt_next = cnt_reg - 5'h1;
    end
  end
  // State and done pulse
  always_ff @(posedge CLK) begin
    cnt_reg <= RST ? 5'h0 : cnt_next;
    STACK_DONE <= !RST && cnt_reg == 5'h1;
  end
endmodule
`default_nettype wire

// [irc_ctrl_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module irc_ctrl_sva (
  input wire logic CLK,
  input wire logic RST,
  input wire logic RESET_IN_N,
  input wire logic STANDBY_IN_N,
  input wire logic SLEEP_INSTRUCTION,
  input wire logic COND_CODE_MASK,
  input wire logic STACK_DONE,
  input wire logic RAM_RANGE_ACCESS,
  input wire logic E_TICK,
  input wire logic CPU_RESET,
  input wire logic ADDR_HIZ,
  input wire logic STACK_REQ,
  input wire logic VECTOR_FETCH,
  input wire logic [15:0] VECTOR_ADDR,
  input wire logic MASK_SET,
  input wire logic CPU_HALT,
  input wire logic WAKE_CONTINUE,
  input wire logic RAM_EXTERNAL
);
  // ==========
  // Clocking and named steps
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  sequence e_gap_s;
    !E_TICK [*3] ##1 E_TICK;
  endsequence
  sequence req_pulse_s;
    STACK_REQ ##1 !STACK_REQ;
  endsequence
  // ==========
  // Checks
  e_period_a: assert property (E_TICK |=> e_gap_s)
    else $error("system tick spacing wrong");
  stack_pulse_a: assert property ($rose(STACK_REQ) |-> req_pulse_s)
    else $error("stack request not one cycle");
  done_fetch_a: assert property (STACK_DONE |=> VECTOR_FETCH)
    else $error("no vector fetch after stacking");
  fetch_mask_a: assert property (VECTOR_FETCH |-> MASK_SET ##1 !VECTOR_FETCH)
    else $error("vector fetch without mask set");
  mask_block_a: assert property ($rose(STACK_REQ) && VECTOR_ADDR[15:4] == 12'hFFF
    && VECTOR_ADDR[3:0] <= 4'h8 |-> !$past(COND_CODE_MASK))
    else $error("maskable request taken while masked");
  vector_pair_a: assert property (VECTOR_FETCH |-> !VECTOR_ADDR[0]
    && (VECTOR_ADDR[15:4] == 12'hFFF || VECTOR_ADDR == 16'hFFEE))
    else $error("vector address outside table");
  float_hold_a: assert property ($rose(ADDR_HIZ) |-> CPU_RESET
    && !($past(RESET_IN_N, 8) && $past(STANDBY_IN_N, 8)))
    else $error("address float too early");
  reset_release_a: assert property ($fell(CPU_RESET) |-> VECTOR_FETCH
    && MASK_SET && !STACK_REQ && VECTOR_ADDR == 16'hFFFE)
    else $error("reset release sequence wrong");
  halt_cause_a: assert property ($rose(CPU_HALT) |-> $past(SLEEP_INSTRUCTION))
    else $error("halt without sleep");
  wake_exit_a: assert property (WAKE_CONTINUE |-> $past(CPU_HALT) ##1 !CPU_HALT)
    else $error("continue pulse outside sleep");
  ram_ext_a: assert property (RAM_EXTERNAL |-> $past(RAM_RANGE_ACCESS))
    else $error("external routing without access");
endmodule
bind irc_ctrl irc_ctrl_sva i_irc_ctrl_sva (.CLK, .RST, .RESET_IN_N, .STANDBY_IN_N,
  .SLEEP_INSTRUCTION, .COND_CODE_MASK, .STACK_DONE, .RAM_RANGE_ACCESS, .E_TICK, .CPU_RESET,
  .ADDR_HIZ, .STACK_REQ, .VECTOR_FETCH, .VECTOR_ADDR, .MASK_SET, .CPU_HALT, .WAKE_CONTINUE,
  .RAM_EXTERNAL);
`default_nettype wire

// [irc_ctrl_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module irc_ctrl_bench
  import irc_pkg::*;
;
  logic CLK, RST, RESET_IN_N, STANDBY_IN_N, SUPPLY_LOST, EXT_MASKABLE_REQ_N, NMI_REQ_N;
  logic CAPTURE_FLAG, CAPTURE_IE, COMPARE_FLAG, COMPARE_IE, OVERFLOW_FLAG, OVERFLOW_IE;
  logic RX_FULL_FLAG, RX_ERROR_FLAG, RX_IE, TX_EMPTY_FLAG, TX_IE, COND_CODE_MASK;
  logic INSTR_BOUNDARY, SOFT_INTERRUPT_INSTR, UNDEFINED_OPCODE, FETCH_ADDR_ERROR;
  logic SLEEP_INSTRUCTION, STACK_DONE, RAM_RANGE_ACCESS, WR_STB, RD_STB, hit;
  logic E_TICK, CPU_RESET, ADDR_HIZ, STACK_REQ, VECTOR_FETCH, MASK_SET, CPU_HALT;
  logic WAKE_CONTINUE, RAM_EXTERNAL;
  logic [2:0] PORT2_LOW, BOOT_MODE;
  logic [7:0] ADDR, WR_DATA, RD_DATA, rd_val, d;
  logic [15:0] VECTOR_ADDR;
  logic [3:0] done_delay;
  int fail_count, total_checks, seed;
  // ==========
  // Design and CPU partner
  irc_ctrl i_irc_ctrl (.CLK, .RST, .RESET_IN_N, .STANDBY_IN_N, .SUPPLY_LOST, .PORT2_LOW,
    .EXT_MASKABLE_REQ_N, .NMI_REQ_N, .CAPTURE_FLAG, .CAPTURE_IE, .COMPARE_FLAG, .COMPARE_IE,
    .OVERFLOW_FLAG, .OVERFLOW_IE, .RX_FULL_FLAG, .RX_ERROR_FLAG, .RX_IE, .TX_EMPTY_FLAG,
    .TX_IE, .COND_CODE_MASK, .INSTR_BOUNDARY, .SOFT_INTERRUPT_INSTR, .UNDEFINED_OPCODE,
    .FETCH_ADDR_ERROR, .SLEEP_INSTRUCTION, .STACK_DONE, .RAM_RANGE_ACCESS, .ADDR, .WR_DATA,
    .WR_STB, .RD_STB, .RD_DATA, .E_TICK, .CPU_RESET, .ADDR_HIZ, .BOOT_MODE, .STACK_REQ,
    .VECTOR_FETCH, .VECTOR_ADDR, .MASK_SET, .CPU_HALT, .WAKE_CONTINUE, .RAM_EXTERNAL);
  irc_cpu_model i_irc_cpu_model (.CLK, .RST, .STACK_REQ, .DELAY(done_delay), .STACK_DONE);
  // ==========
  // Clock
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // ==========
  // Helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  function automatic logic [15:0] exp_vec(input int s);
    logic [15:0] t [8] = '{16'hFFEE, 16'hFFFC, 16'hFFFA, 16'hFFF8, 16'hFFF6, 16'hFFF4,
      16'hFFF2, 16'hFFF0};
    return t[s];
  endfunction
  function automatic logic sig(input int sel);
    case (sel)
      0: return VECTOR_FETCH;
      1: return WAKE_CONTINUE;
      2: return STACK_REQ;
      default: return CPU_RESET;
    endcase
  endfunction
  // Bounded wait for a design output
  task automatic wait_hi(input int sel);
    hit = 1'b0;
    repeat (40) if (!hit) begin
      @(posedge CLK);
      #1;
      hit = sig(sel);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    WR_DATA <= v;
    WR_STB <= 1'b1;
    @(posedge CLK);
    WR_STB <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLK);
    RD_STB <= 1'b0;
    #1;
    rd_val = RD_DATA;
  endtask
  // Raise or drop one request source
  task automatic set_src(input int s, input logic v);
    int k;
    k = $unsigned($random(seed)) % 3;
    @(posedge CLK);
    case (s)
      0: {UNDEFINED_OPCODE, FETCH_ADDR_ERROR} <= v ? 2'(1 << k[0]) : 2'h0;
      1: NMI_REQ_N <= !v;
      2: SOFT_INTERRUPT_INSTR <= v;
      3: EXT_MASKABLE_REQ_N <= !v;
      4: CAPTURE_FLAG <= v;
      5: COMPARE_FLAG <= v;
      6: OVERFLOW_FLAG <= v;
      default: {RX_FULL_FLAG, RX_ERROR_FLAG, TX_EMPTY_FLAG} <= v ? 3'(1 << k) : 3'h0;
    endcase
    @(posedge CLK);
    {UNDEFINED_OPCODE, FETCH_ADDR_ERROR, SOFT_INTERRUPT_INSTR, SLEEP_INSTRUCTION} <= 4'h0;
  endtask
  task automatic boundary(input logic [15:0] vec, input logic taken);
    cyc(9);
    INSTR_BOUNDARY <= 1'b1;
    done_delay <= 4'($random(seed));
    @(posedge CLK);
    INSTR_BOUNDARY <= 1'b0;
    #1;
    check("stack request", 16'(STACK_REQ), 16'(taken));
    if (taken) begin
      check("vector", VECTOR_ADDR, vec);
      wait_hi(0);
      check("fetch with mask", 16'(MASK_SET & hit), 16'h1);
    end
    cyc(2);
  endtask
  task automatic sleep_now(input logic m);
    @(posedge CLK);
    COND_CODE_MASK <= m;
    SLEEP_INSTRUCTION <= 1'b1;
    @(posedge CLK);
    SLEEP_INSTRUCTION <= 1'b0;
    cyc(12);
  endtask
  task automatic release_check();
    logic [2:0] p;
    p = 3'($random(seed));
    @(posedge CLK);
    PORT2_LOW <= p;
    RESET_IN_N <= 1'b1;
    STANDBY_IN_N <= 1'b1;
    wait_hi(0);
    check("boot mode", 16'(BOOT_MODE), 16'(p));
    check("reset vector", VECTOR_ADDR, 16'hFFFE);
    check("reset mask", 16'({MASK_SET, CPU_RESET, ADDR_HIZ}), 16'h4);
    reg_rd(8'h14);
    check("ram enable", 16'(rd_val[6]), 16'h1);
  endtask
  // ==========
  // Watchdog
  initial begin
    cyc(20000);
    fail_count++;
    close_out();
  end
  // ==========
  // Main sequence
  initial begin
    seed = 32'h50AF2854;
    RST = 1'b1;
    {SUPPLY_LOST, CAPTURE_FLAG, COMPARE_FLAG, OVERFLOW_FLAG, RX_FULL_FLAG, RX_ERROR_FLAG,
      TX_EMPTY_FLAG, INSTR_BOUNDARY, SOFT_INTERRUPT_INSTR, UNDEFINED_OPCODE, FETCH_ADDR_ERROR,
      SLEEP_INSTRUCTION, RAM_RANGE_ACCESS, WR_STB, RD_STB, RESET_IN_N} = '0;
    {STANDBY_IN_N, EXT_MASKABLE_REQ_N, NMI_REQ_N, CAPTURE_IE, COMPARE_IE, OVERFLOW_IE, RX_IE,
      TX_IE, COND_CODE_MASK} = '1;
    {ADDR, WR_DATA, PORT2_LOW, done_delay} = '0;
    cyc(10);
    RST <= 1'b0;
    release_check();
    $display("test power up done");
    d = 8'($random(seed));
    reg_wr(8'h14, d);
    reg_wr(8'h21, 8'hFF);
    reg_rd(8'h14);
    check("ram control", 16'(rd_val), 16'({d[7:6], 6'h0}));
    reg_rd(8'h20);
    check("unmapped read", 16'(rd_val), 16'h0);
    reg_wr(8'h14, 8'hC0);
    @(posedge CLK);
    SUPPLY_LOST <= 1'b1;
    @(posedge CLK);
    SUPPLY_LOST <= 1'b0;
    reg_rd(8'h14);
    check("supply loss", 16'(rd_val), 16'h40);
    reg_wr(8'h14, 8'h00);
    RAM_RANGE_ACCESS <= 1'b1;
    cyc(2);
    #1;
    check("ram external", 16'(RAM_EXTERNAL), 16'h1);
    reg_wr(8'h14, 8'h40);
    cyc(2);
    #1;
    check("ram internal", 16'(RAM_EXTERNAL), 16'h0);
    $display("test registers done");
    for (int s = 0; s < 8; s++) begin
      @(posedge CLK);
      COND_CODE_MASK <= (s < 3);
      set_src(s, 1'b1);
      boundary(exp_vec(s), 1'b1);
      set_src(s, 1'b0);
    end
    set_src(3, 1'b1);
    set_src(4, 1'b1);
    boundary(16'hFFF8, 1'b1);
    set_src(3, 1'b0);
    boundary(16'hFFF6, 1'b1);
    set_src(0, 1'b1);
    boundary(16'hFFEE, 1'b1);
    set_src(4, 1'b0);
    @(posedge CLK);
    COND_CODE_MASK <= 1'b1;
    set_src(3, 1'b1);
    boundary(16'h0, 1'b0);
    reg_rd(8'h15);
    check("status", 16'(rd_val), 16'h02);
    set_src(3, 1'b0);
    set_src(5, 1'b1);
    boundary(16'h0, 1'b0);
    COND_CODE_MASK <= 1'b0;
    COMPARE_IE <= 1'b0;
    boundary(16'h0, 1'b0);
    $display("test interrupts done");
    sleep_now(1'b1);
    #1;
    check("halted", 16'(CPU_HALT), 16'h1);
    set_src(3, 1'b1);
    wait_hi(1);
    check("masked wake", 16'(hit), 16'h1);
    set_src(3, 1'b0);
    cyc(9);
    sleep_now(1'b0);
    set_src(4, 1'b1);
    wait_hi(2);
    check("wake vector", VECTOR_ADDR, 16'hFFF6);
    wait_hi(0);
    set_src(4, 1'b0);
    cyc(9);
    sleep_now(1'b1);
    STANDBY_IN_N <= 1'b0;
    wait_hi(3);
    check("standby wake", 16'(hit), 16'h1);
    release_check();
    $display("test sleep done");
    reg_wr(8'h14, 8'h00);
    RESET_IN_N <= 1'b0;
    cyc(8);
    #1;
    check("early float", 16'({CPU_RESET, ADDR_HIZ}), 16'h2);
    cyc(20);
    #1;
    check("reset float", 16'({CPU_RESET, ADDR_HIZ}), 16'h3);
    release_check();
    $display("test reset done");
    close_out();
  end
endmodule
`default_nettype wire
